// >>> logic/psor_pkg.sv
/*
  constants, register map and state types of the slot/offset serial receiver.
  assumes a 16-bit register space reached over the two-wire control port.
*/
package psor_pkg;
  localparam logic [15:0] REG_FULL_RST = 16'h0000;
  localparam logic [15:0] REG_SOFT_RST = 16'h0001;
  localparam logic [15:0] REG_ID       = 16'h0002;
  localparam logic [15:0] REG_OFFS_CTL = 16'h000C;
  localparam logic [15:0] REG_WLEN     = 16'h000D;
  localparam logic [15:0] REG_SLOT_CTL = 16'h000E;
  localparam logic [15:0] REG_LSLOT    = 16'h000F;
  localparam logic [15:0] REG_RSLOT    = 16'h0010;
  localparam logic [15:0] REG_DAC_CLK  = 16'h0020;
  localparam int OFFS_BIT = 14;
  localparam int WLEN_LSB = 2;
  localparam int SLOT_BIT = 10;
  localparam int DINV_BIT = 0;
  localparam int DDIV_LSB = 1;
  // arbitrary identification value
  localparam logic [15:0] ID_VALUE = 16'h5A5A;
  localparam logic [6:0]  BUS_ADDR = 7'h21;
  localparam logic [2:0]  CH_LAST_TDM  = 3'h7;
  localparam logic [2:0]  CH_LAST_PAIR = 3'h1;
  localparam logic [10:0] IDX_MAX = 11'h7FF;

  typedef enum logic [4:0] {
    BS_IDLE = 5'h01,
    BS_RX   = 5'h02,
    BS_ACK  = 5'h04,
    BS_TX   = 5'h08,
    BS_TACK = 5'h10
  } psor_bus_t;

  typedef struct packed {
    logic       offm;
    logic [2:0] wl;
    logic       slot_en;
    logic [9:0] lslot;
    logic [9:0] rslot;
    logic       dinv;
    logic [1:0] ddiv;
  } psor_cfg_t;
  localparam psor_cfg_t CFG_RST = '0;

  typedef struct packed {
    logic        fsp;
    logic [10:0] idx;
    logic        busy;
    logic        done;
    logic [2:0]  ch;
    logic [5:0]  cnt;
    logic [31:0] sh;
    logic [31:0] smp;
    logic [2:0]  sch;
    logic        vld;
  } psor_au_t;
  localparam psor_au_t AU_RST = '0;

  typedef struct packed {
    logic [2:0] scl;
    logic [2:0] sda;
    logic [2:0] bclk;
    logic [1:0] fs;
    logic [1:0] din;
    psor_bus_t  bs;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [2:0] bidx;
    logic       rw;
    logic       nack;
    logic       half;
    logic       oe;
    logic       soft_arm;
    logic [15:0] ptr;
    logic [7:0] dhi;
    psor_cfg_t  cfg;
    psor_au_t   au;
  } psor_st_t;
  localparam psor_st_t ST_RST = '{bs: BS_IDLE, cfg: CFG_RST, au: AU_RST, default: '0};

  function automatic logic [5:0] psor_wlen(input logic [2:0] c);
    case (c)
      3'h0: return 6'h10;
      3'h1: return 6'h14;
      3'h2: return 6'h18;
      3'h3: return 6'h20;
      default: return 6'h08;
    endcase
  endfunction
endpackage

// >>> logic/psor_top.sv
/*
  slot/offset serial audio receiver with two-wire register port.
  assumes bit clock, frame sync and data come from an external master;
  all pins are asynchronous to core_clk_i and are synchronised here.
*/
`timescale 1ns/1ns
module psor_top
  import psor_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output wire logic        sda_o,
  output wire logic        sda_oe_o,
  input  wire logic        bclk_i,
  input  wire logic        frame_sync_i,
  input  wire logic        sdin_i,
  output wire logic [31:0] sample_o,
  output wire logic [2:0]  sample_ch_o,
  output wire logic        sample_vld_o,
  output wire logic        dac_clk_inv_o,
  output wire logic [1:0]  dac_clk_div_o
);

  logic [1:0]  rst_sync_r;
  logic        rst_q_n;
  psor_st_t    q;
  psor_st_t    n;
  logic        sr;
  logic        sf;
  logic        b_start;
  logic        b_stop;
  logic        wr_go;
  logic        full_go;
  logic        soft_go;
  logic [15:0] wdat;
  logic [15:0] rdv;
  logic [7:0]  tb;
  logic        rise;
  logic        fstart;
  logic        slot_m;
  logic        dly;
  logic [10:0] idx;
  logic [10:0] tgt;
  logic        bsy;
  logic        dn;
  logic [2:0]  chv;
  logic [5:0]  cntv;
  logic [5:0]  wlb;
  logic        srt;
  logic        cap;
  logic        last;

  function automatic logic [15:0] rd_reg(input psor_st_t s, input logic [15:0] a);
    logic [15:0] v;
    v = 16'h0000;
    if (a == REG_ID)
      v = ID_VALUE;
    else if (a == REG_OFFS_CTL)
      v[OFFS_BIT] = s.cfg.offm;
    else if (a == REG_WLEN)
      v[WLEN_LSB+:3] = s.cfg.wl;
    else if (a == REG_SLOT_CTL)
      v[SLOT_BIT] = s.cfg.slot_en;
    else if (a == REG_LSLOT)
      v[9:0] = s.cfg.lslot;
    else if (a == REG_RSLOT)
      v[9:0] = s.cfg.rslot;
    else if (a == REG_DAC_CLK)
    begin
      v[DINV_BIT] = s.cfg.dinv;
      v[DDIV_LSB+:2] = s.cfg.ddiv;
    end
    return v;
  endfunction

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_q_n = rst_sync_r[1];

  always_comb
  begin
    n = q;
    n.scl = {q.scl[1:0], scl_i};
    n.sda = {q.sda[1:0], sda_i};
    n.bclk = {q.bclk[1:0], bclk_i};
    n.fs = {q.fs[0], frame_sync_i};
    n.din = {q.din[0], sdin_i};
    n.au.vld = 1'b0;
    wr_go = 1'b0;
    full_go = 1'b0;
    soft_go = 1'b0;
    wdat = {q.dhi, q.sh};
    rdv = rd_reg(q, q.ptr);
    tb = q.half ? rdv[7:0] : rdv[15:8];
    sr = q.scl[1] & ~q.scl[2];
    sf = ~q.scl[1] & q.scl[2];
    b_start = q.scl[1] & q.scl[2] & q.sda[2] & ~q.sda[1];
    b_stop = q.scl[1] & q.scl[2] & ~q.sda[2] & q.sda[1];
    // control port: address, pointer, data bytes
    if (b_start)
    begin
      n.bs = BS_RX;
      n.bitc = 4'h0;
      n.bidx = 3'h0;
      n.oe = 1'b0;
    end
    else if (b_stop)
    begin
      n.bs = BS_IDLE;
      n.oe = 1'b0;
    end
    else
    begin
      case (q.bs)
        BS_IDLE: n.oe = 1'b0;
        BS_RX:
          if (sr)
          begin
            n.sh = {q.sh[6:0], q.sda[1]};
            n.bitc = q.bitc + 4'h1;
          end
          else if (sf && q.bitc == 4'h8)
          begin
            n.bs = BS_ACK;
            n.oe = 1'b1;
            n.bitc = 4'h0;
            if (q.bidx == 3'h0)
            begin
              n.rw = q.sh[0];
              n.half = 1'b0;
              n.bidx = 3'h1;
              if (q.sh[7:1] != BUS_ADDR)
              begin
                n.bs = BS_IDLE;
                n.oe = 1'b0;
              end
            end
            else if (q.bidx == 3'h1)
            begin
              n.ptr[15:8] = q.sh;
              n.bidx = 3'h2;
            end
            else if (q.bidx == 3'h2)
            begin
              n.ptr[7:0] = q.sh;
              n.bidx = 3'h3;
            end
            else if (q.bidx == 3'h3)
            begin
              n.dhi = q.sh;
              n.bidx = 3'h4;
            end
            else
            begin
              wr_go = 1'b1;
              n.bidx = 3'h3;
              n.ptr = q.ptr + 16'h0001;
            end
          end
        BS_ACK:
          if (sf)
          begin
            n.oe = 1'b0;
            n.bs = BS_RX;
            if (q.rw)
            begin
              n.bs = BS_TX;
              n.sh = tb;
              n.oe = ~tb[7];
              n.half = 1'b1;
            end
          end
        BS_TX:
          if (sf)
          begin
            if (q.bitc == 4'h7)
            begin
              n.bs = BS_TACK;
              n.oe = 1'b0;
            end
            else
            begin
              n.sh = {q.sh[6:0], 1'b0};
              n.oe = ~q.sh[6];
              n.bitc = q.bitc + 4'h1;
            end
          end
        BS_TACK:
          if (sr)
            n.nack = q.sda[1];
          else if (sf)
          begin
            n.bs = BS_IDLE;
            if (!q.nack)
            begin
              n.bs = BS_TX;
              n.bitc = 4'h0;
              n.sh = tb;
              n.oe = ~tb[7];
              n.half = ~q.half;
              if (q.half)
                n.ptr = q.ptr + 16'h0001;
            end
          end
        default: n.bs = BS_IDLE;
      endcase
    end
    // register writes
    if (wr_go)
    begin
      n.soft_arm = 1'b0;
      if (q.ptr == REG_FULL_RST)
        full_go = 1'b1;
      else if (q.ptr == REG_SOFT_RST)
      begin
        soft_go = q.soft_arm;
        n.soft_arm = ~q.soft_arm;
      end
      else if (q.ptr == REG_OFFS_CTL)
        n.cfg.offm = wdat[OFFS_BIT];
      else if (q.ptr == REG_WLEN)
        n.cfg.wl = wdat[WLEN_LSB+:3];
      else if (q.ptr == REG_SLOT_CTL)
        n.cfg.slot_en = wdat[SLOT_BIT];
      else if (q.ptr == REG_LSLOT)
        n.cfg.lslot = wdat[9:0];
      else if (q.ptr == REG_RSLOT)
        n.cfg.rslot = wdat[9:0];
      else if (q.ptr == REG_DAC_CLK)
      begin
        n.cfg.dinv = wdat[DINV_BIT];
        n.cfg.ddiv = wdat[DDIV_LSB+:2];
      end
    end
    // serial receive path, slave to external clocks
    rise = q.bclk[1] & ~q.bclk[2];
    fstart = rise & q.fs[1] & ~q.au.fsp;
    slot_m = q.cfg.slot_en & ~q.cfg.offm;
    dly = slot_m | q.cfg.offm;
    idx = fstart ? 11'h000 : ((q.au.idx == IDX_MAX) ? q.au.idx : q.au.idx + 11'h001);
    bsy = fstart ? 1'b0 : q.au.busy;
    dn = fstart ? 1'b0 : q.au.done;
    chv = fstart ? 3'h0 : q.au.ch;
    cntv = fstart ? 6'h00 : q.au.cnt;
    wlb = psor_wlen(q.cfg.wl);
    tgt = !dly ? 11'h000 : ((chv == 3'h0) ? {1'b0, q.cfg.lslot} : {1'b0, q.cfg.rslot});
    srt = rise & ~bsy & ~dn & (idx == tgt);
    cap = rise & (bsy | srt);
    last = (chv == (q.cfg.offm ? CH_LAST_TDM : CH_LAST_PAIR));
    if (rise)
    begin
      n.au.fsp = q.fs[1];
      n.au.idx = idx;
      n.au.busy = bsy;
      n.au.done = dn;
      n.au.ch = chv;
      n.au.cnt = cntv;
      if (fstart)
        n.au.sh = 32'h00000000;
    end
    if (cap)
    begin
      n.au.busy = 1'b1;
      n.au.sh = {(fstart ? 31'h00000000 : q.au.sh[30:0]), q.din[1]};
      n.au.cnt = cntv + 6'h01;
      if (cntv == wlb - 6'h01)
      begin
        n.au.smp = n.au.sh;
        n.au.sh = 32'h00000000;
        n.au.sch = chv;
        n.au.vld = 1'b1;
        n.au.cnt = 6'h00;
        n.au.ch = chv + 3'h1;
        n.au.busy = ~last & ~slot_m;
        n.au.done = last;
      end
    end
    if (soft_go)
      n.au = AU_RST;
    if (full_go)
      n.cfg = CFG_RST;
  end

  always_ff @(posedge core_clk_i or negedge rst_q_n)
  begin
    if (!rst_q_n)
      q <= ST_RST;
    else
      q <= n;
  end

  assign sda_o         = 1'b0;
  assign sda_oe_o      = q.oe;
  assign sample_o      = q.au.smp;
  assign sample_ch_o   = q.au.sch;
  assign sample_vld_o  = q.au.vld;
  assign dac_clk_inv_o = q.cfg.dinv;
  assign dac_clk_div_o = q.cfg.ddiv;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_q_n);

  chk_full_reset_cfg: assert property (wr_go && q.ptr == REG_FULL_RST |=> q.cfg == CFG_RST)
    else $error("full reset write left config set");
  chk_soft_keeps_cfg: assert property (soft_go |=> $stable(q.cfg) && !q.au.busy && !q.au.vld)
    else $error("soft reset changed config or kept datapath");
  chk_soft_needs_two: assert property (wr_go && q.ptr == REG_SOFT_RST && !q.soft_arm |-> !soft_go)
    else $error("single soft write acted");
  chk_no_delay_start: assert property (fstart && !dly |-> cap)
    else $error("plain mode missed first edge");
  chk_left_delay: assert property (rise && !bsy && !dn && chv == 3'h0 && dly &&
    idx == {1'b0, q.cfg.lslot} |-> cap)
    else $error("left or channel 0 start missed");
  chk_right_delay: assert property (rise && slot_m && !bsy && chv == 3'h1 && !dn &&
    idx == {1'b0, q.cfg.rslot} |-> cap)
    else $error("right slot start missed");
  chk_start_exact: assert property (cap && !bsy |-> idx == tgt)
    else $error("capture started off its delay");
  chk_offset_chain: assert property (sample_vld_o && q.cfg.offm && sample_ch_o != CH_LAST_TDM |-> q.au.busy)
    else $error("gap between offset channels");
  chk_word_length: assert property (cap && cntv == wlb - 6'h01 && !soft_go |=>
    sample_vld_o && sample_ch_o == $past(chv))
    else $error("word not closed at its length");
  chk_on_rise_only: assert property (cap |-> rise)
    else $error("capture without bit clock rise");
  chk_dac_clock_ctl: assert property (wr_go && q.ptr == REG_DAC_CLK |=>
    dac_clk_inv_o == $past(wdat[DINV_BIT]) && dac_clk_div_o == $past(wdat[DDIV_LSB+:2]))
    else $error("dac clock control not taken");

  cov_offset_tdm: cover property (sample_vld_o && q.cfg.offm && sample_ch_o == CH_LAST_TDM);
  cov_slot_right: cover property (sample_vld_o && slot_m && sample_ch_o == 3'h1);
  cov_full_reset: cover property (full_go);
  cov_soft_reset: cover property (soft_go);
endmodule

// >>> dv/psor_ctrl_model.sv
/*
  external audio master: bit clock, frame sync and serial data.
  assumes callers enter its task on a core_clk_i rising edge.
*/
`timescale 1ns/1ns
module psor_ctrl_model
(
  input  wire logic core_clk_i,
  output logic      bclk_o,
  output logic      fs_o,
  output logic      sd_o
);
  initial
  begin
    bclk_o = 1'b0;
    fs_o   = 1'b0;
    sd_o   = 1'b0;
  end

  // one bit-clock rise: 7 cycles low, 3 high, lines move 2 cycles into the low phase
  task automatic rise(input logic f, input logic d);
    bclk_o <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    fs_o <= f;
    sd_o <= d;
    repeat (5) @(posedge core_clk_i);
    bclk_o <= 1'b1;
    repeat (3) @(posedge core_clk_i);
  endtask

  // bits[i] goes out at rise i; clock stands still after the frame
  task automatic frame(input logic [511:0] bits, input int n);
    rise(1'b0, ~sd_o);
    for (int i = 0; i < n; i++)
      rise(i == 0, bits[i]);
    bclk_o <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    sd_o <= ~sd_o;
  endtask
endmodule

// >>> dv/psor_top_tb.sv
/*
  self-checking bench for the slot/offset serial receiver.
  assumes psor_ctrl_model drives the audio pins; the bench is the
  two-wire master and resolves the open-drain data line itself.
*/
`timescale 1ns/1ns
module psor_top_tb;
  import psor_pkg::*;
  logic        clk        = 1'b0;
  logic        rst_n      = 1'b0;
  logic        scl        = 1'b1;
  logic        msda       = 1'b1;
  wire logic   sda_oe, sda_do;
  wire logic   sda_w      = msda & (~sda_oe | sda_do);
  wire logic   bclk, fs, sd, vld, inv;
  wire logic [31:0] smp;
  wire logic [2:0]  sch;
  wire logic [1:0]  div;
  logic [34:0] expq[$];
  logic [31:0] seed       = 32'h0B755FD2;
  int          wlt[5]     = '{16, 20, 24, 32, 8};
  int          fails      = 0;
  int          n_compared = 0;
  int          cyc        = 0;
  logic [7:0]  bq;
  logic        bak;

  always #4 clk = ~clk;

  psor_top u_psor_top (
    .core_clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_do), .sda_oe_o(sda_oe),
    .bclk_i(bclk), .frame_sync_i(fs), .sdin_i(sd), .sample_o(smp), .sample_ch_o(sch),
    .sample_vld_o(vld), .dac_clk_inv_o(inv), .dac_clk_div_o(div));

  psor_ctrl_model u_psor_ctrl_model (.core_clk_i(clk), .bclk_o(bclk), .fs_o(fs), .sd_o(sd));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic w5;
    repeat (5) @(posedge clk);
  endtask

  task automatic bitx(input logic b, output logic r);
    msda <= b;
    w5;
    scl <= 1'b1;
    w5;
    r = sda_w;
    w5;
    scl <= 1'b0;
    w5;
  endtask

  // a=1: start or repeated start, a=0: stop
  task automatic cond(input logic a);
    msda <= a;
    w5;
    scl <= 1'b1;
    w5;
    msda <= ~a;
    w5;
    if (a)
    begin
      scl <= 1'b0;
      w5;
    end
  endtask

  task automatic xfer(input logic [7:0] d, input logic ma, output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(ma, ak);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [7:0] q;
    logic       ak;
    cond(1'b1);
    xfer({BUS_ADDR, 1'b0}, 1'b1, q, ak);
    chk(ak, 1'b0);
    xfer(a[15:8], 1'b1, q, ak);
    xfer(a[7:0], 1'b1, q, ak);
    xfer(d[15:8], 1'b1, q, ak);
    xfer(d[7:0], 1'b1, q, ak);
    cond(1'b0);
  endtask

  task automatic rc(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic [7:0]  q;
    logic        ak;
    cond(1'b1);
    xfer({BUS_ADDR, 1'b0}, 1'b1, q, ak);
    xfer(a[15:8], 1'b1, q, ak);
    xfer(a[7:0], 1'b1, q, ak);
    cond(1'b1);
    xfer({BUS_ADDR, 1'b1}, 1'b1, q, ak);
    xfer(8'hFF, 1'b0, d[15:8], ak);
    xfer(8'hFF, 1'b1, d[7:0], ak);
    cond(1'b0);
    chk(d, e);
  endtask

  // random filler everywhere, words placed at their expected rises
  task automatic send(input int nch, input int s0, input int s1, input int wl, input logic b2b);
    logic [511:0] v;
    logic [31:0]  w;
    int           st;
    for (int i = 0; i < 512; i++)
    begin
      seed = lfsr(seed);
      v[i] = seed[0];
    end
    st = s0;
    for (int k = 0; k < nch; k++)
    begin
      if (k == 1 && !b2b)
        st = s1;
      seed = lfsr(seed);
      w = seed >> (32 - wl);
      expq.push_back({k[2:0], w});
      for (int b = 0; b < wl; b++)
        v[st + b] = w[wl - 1 - b];
      st += wl;
    end
    u_psor_ctrl_model.frame(v, st);
    repeat (20) @(posedge clk);
    chk(expq.size(), 0);
  endtask

  always @(posedge clk)
    if (vld === 1'b1)
      chk({sch, smp}, expq.size() > 0 ? {29'h0, expq.pop_front()} : '1);

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      fails++;
      close_out;
    end
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({inv, div}, 3'h0);
    rc(REG_ID, ID_VALUE);
    wr(REG_ID, 16'h1234);
    rc(REG_ID, ID_VALUE);
    rc(16'h0030, 16'h0000);
    cond(1'b1);
    xfer({BUS_ADDR ^ 7'h01, 1'b0}, 1'b1, bq, bak);
    chk(bak, 1'b1);
    cond(1'b0);
    wr(REG_DAC_CLK, 16'h0007);
    chk({inv, div}, 3'h7);
    wr(REG_DAC_CLK, 16'h0002);
    chk({inv, div}, 3'h1);
    $display("test registers done");
    send(2, 0, 0, 16, 1'b1);
    $display("test plain done");
    wr(REG_SLOT_CTL, 16'h0400);
    wr(REG_LSLOT, 16'h0003);
    wr(REG_RSLOT, 16'h0028);
    send(2, 3, 40, 16, 1'b0);
    $display("test slot done");
    wr(REG_OFFS_CTL, 16'h4000);
    for (int c = 0; c < 5; c++)
    begin
      wr(REG_WLEN, 16'(c << WLEN_LSB));
      send(8, 3, 0, wlt[c], 1'b1);
    end
    $display("test offset done");
    wr(REG_SOFT_RST, 16'h0000);
    chk(sch, CH_LAST_TDM);
    wr(REG_SOFT_RST, 16'h0000);
    chk({sch, smp}, 35'h0);
    rc(REG_LSLOT, 16'h0003);
    send(8, 3, 0, 8, 1'b1);
    $display("test soft reset done");
    wr(REG_FULL_RST, 16'h0000);
    chk({inv, div}, 3'h0);
    rc(REG_LSLOT, 16'h0000);
    send(2, 0, 0, 16, 1'b1);
    $display("test full reset done");
    close_out;
  end
endmodule
